// >>> ecp_pkg.sv
// Shared constants for the event counter and pulse width timer.
package ecp_pkg;

    // Operating modes held in the mode select pair.
    typedef enum logic [1:0] {
        ECP_MODE_IDLE  = 2'b00,
        ECP_MODE_EVENT = 2'b01,
        ECP_MODE_TIMER = 2'b10,
        ECP_MODE_PULSE = 2'b11
    } ecp_mode_t;

    // Pulse width measurement sequencer states.
    typedef enum logic [1:0] {
        ECP_PW_IDLE    = 2'b00,
        ECP_PW_ARMED   = 2'b01,
        ECP_PW_MEASURE = 2'b10
    } ecp_pw_state_t;

    // Register byte offsets on the bus.
    localparam logic [7:0] ECP_OFS_CTRL    = 8'h00;
    localparam logic [7:0] ECP_OFS_PRELOAD = 8'h04;
    localparam logic [7:0] ECP_OFS_COUNT   = 8'h08;
    localparam logic [7:0] ECP_OFS_STATUS  = 8'h0C;
    localparam logic [7:0] ECP_OFS_MASK    = 8'h10;

    // Control register field positions.
    localparam int ECP_CTRL_MODE_HI  = 7;
    localparam int ECP_CTRL_MODE_LO  = 6;
    localparam int ECP_CTRL_RUN      = 4;
    localparam int ECP_CTRL_EDGE     = 3;
    localparam int ECP_CTRL_PSC_HI   = 2;
    localparam int ECP_CTRL_PSC_LO   = 0;

    // Writable control bits; bit 5 is unused and reads as zero.
    localparam logic [7:0] ECP_CTRL_WMASK = 8'hDF;
    localparam logic [7:0] ECP_CTRL_RESET = 8'h00;

    // Interrupt status and mask bit positions.
    localparam int ECP_IRQ_OVF  = 0;
    localparam int ECP_IRQ_WAKE = 1;
    localparam int ECP_IRQ_W    = 2;

    // Prescaler: ratio code width and longest divide stage count.
    localparam int ECP_PSC_SEL_W = 3;
    localparam int ECP_PSC_CNT_W = 7;

endpackage

// >>> ecp_pin_sync.sv
// Two-stage synchroniser and edge detector for the shared count input pin.
`timescale 1ns/1ps
module ecp_pin_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      pin_level,
    output logic      pin_rise,
    output logic      pin_fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign pin_level = sync_ff;
    assign pin_rise  = sync_ff & ~prev_ff;
    assign pin_fall  = ~sync_ff & prev_ff;
endmodule

// >>> ecp_prescaler.sv
// Power-of-two prescaler that yields one tick every 2^sel clocks.
`timescale 1ns/1ps
module ecp_prescaler #(
    parameter int SEL_W = ecp_pkg::ECP_PSC_SEL_W,
    parameter int CNT_W = ecp_pkg::ECP_PSC_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick
);
    logic [CNT_W-1:0] div_ff;
    logic [CNT_W-1:0] sel_mask;

    // Ratio code n gives a mask of n low ones: tick when those bits are all set.
    always_comb begin
        sel_mask = '0;
        for (int i = 0; i < CNT_W; i++) begin
            sel_mask[i] = (i < int'(sel));
        end
    end

    // Held at zero while stopped so every run starts with a full period.
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    assign tick = run && ((div_ff & sel_mask) == sel_mask);
endmodule

// >>> ecp_timer.sv
// Event counter and single-shot pulse width timer with Wishbone registers.
//
// Operation
// - Event mode counts pin transitions, no prescaler.
// - Counter runs only when run bit 4 set.
// - Edge bit 3: clear rising, set falling.
// - Overflow raises interrupt, reloads preload, continues.
// - Interrupt enable zero suppresses overflow interrupt.
// - Event mode counts in power-down, overflow wakes.
// - Mode 11 is prescaled pulse width measurement.
// - Bits 0-2 choose prescale 1:1 to 1:128.
// - Pulse mode: enable arms, active edge starts.
// - Edge clear: fall starts, rise stops, clears enable.
// - Edge set: rise starts, fall stops, clears enable.
// - After measurement, edges ignored until rearmed.
// - Hardware clears enable only in pulse mode.
// - Counter holds residual value after measurement.
// - Pulse mode starts and stops on edges only.
// - Mode 10 is prescaled timer mode.
// - Preload loads counter when stopped, else at overflow.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module ecp_timer #(
    parameter int CNT_W = 8
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        shared_count_input_pin,
    input  wire logic        power_down,
    output logic             pin_as_timer_input,
    output logic             wake_req,
    output logic             irq
);
    // Control register and its decoded fields.
    logic [7:0]              ctrl_ff;
    logic [7:0]              nxt_ctrl;
    ecp_pkg::ecp_mode_t      mode;
    logic                    run_enable_bit;
    logic                    active_edge_select;
    logic [2:0]              prescale_rate_sel;

    // Count and preload.
    logic [CNT_W-1:0]        count_ff;
    logic [CNT_W-1:0]        preload_ff;

    // Interrupt status and mask.
    logic [ecp_pkg::ECP_IRQ_W-1:0] status_ff;
    logic [ecp_pkg::ECP_IRQ_W-1:0] mask_ff;

    // Bus handshake.
    logic                    ack_ff;
    logic [31:0]             rdata_ff;
    logic                    bus_req;
    logic                    wr_lane0;
    logic                    wr_ctrl;
    logic                    wr_preload;
    logic                    wr_status;
    logic                    wr_mask;

    // Pin and prescaler.
    logic                    pin_rise;
    logic                    pin_fall;
    logic                    psc_run;
    logic                    psc_tick;

    // Pulse sequencer.
    ecp_pkg::ecp_pw_state_t  pw_state_ff;
    ecp_pkg::ecp_pw_state_t  nxt_pw_state;
    logic                    pw_start_edge;
    logic                    pw_stop_edge;
    logic                    pw_done;

    // Counting.
    logic                    cnt_tick;
    logic                    at_full;
    logic                    overflow;
    logic                    wake_evt;

    // ------------------------------------------------------------------
    // Field decode.
    // ------------------------------------------------------------------
    assign mode = ecp_pkg::ecp_mode_t'(
        {ctrl_ff[ecp_pkg::ECP_CTRL_MODE_HI],
         ctrl_ff[ecp_pkg::ECP_CTRL_MODE_LO]});
    assign run_enable_bit     = ctrl_ff[ecp_pkg::ECP_CTRL_RUN];
    assign active_edge_select = ctrl_ff[ecp_pkg::ECP_CTRL_EDGE];
    assign prescale_rate_sel  =
        ctrl_ff[ecp_pkg::ECP_CTRL_PSC_HI:ecp_pkg::ECP_CTRL_PSC_LO];

    // The port logic outside uses this to hand the pin to the timer;
    // software must still set the pin direction to input.
    assign pin_as_timer_input = (mode == ecp_pkg::ECP_MODE_EVENT) ||
                                (mode == ecp_pkg::ECP_MODE_PULSE);

    // ------------------------------------------------------------------
    // Bus decode. Every access, mapped or not, is acked one cycle later.
    // ------------------------------------------------------------------
    assign bus_req    = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lane0   = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_ctrl    = wr_lane0 && (wb_adr_i == ecp_pkg::ECP_OFS_CTRL);
    assign wr_preload = wr_lane0 && (wb_adr_i == ecp_pkg::ECP_OFS_PRELOAD);
    assign wr_status  = wr_lane0 && (wb_adr_i == ecp_pkg::ECP_OFS_STATUS);
    assign wr_mask    = wr_lane0 && (wb_adr_i == ecp_pkg::ECP_OFS_MASK);

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                ecp_pkg::ECP_OFS_CTRL: begin
                    rdata_ff <= {24'h00_0000, ctrl_ff};
                end
                ecp_pkg::ECP_OFS_PRELOAD: begin
                    rdata_ff <= 32'(preload_ff);
                end
                ecp_pkg::ECP_OFS_COUNT: begin
                    rdata_ff <= 32'(count_ff);
                end
                ecp_pkg::ECP_OFS_STATUS: begin
                    rdata_ff <= 32'(status_ff);
                end
                ecp_pkg::ECP_OFS_MASK: begin
                    rdata_ff <= 32'(mask_ff);
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // ------------------------------------------------------------------
    // Pin synchroniser and prescaler.
    // ------------------------------------------------------------------
    ecp_pin_sync u_pin_sync (
        .clk       (clk),
        .srst      (srst),
        .pin_in    (shared_count_input_pin),
        // Only the edges drive counting; the level itself is not needed.
        .pin_level (),
        .pin_rise  (pin_rise),
        .pin_fall  (pin_fall)
    );

    // The system clock is stopped in power-down, so the prescaled
    // modes freeze there; only event mode keeps counting.
    assign psc_run =
        !power_down &&
        (((mode == ecp_pkg::ECP_MODE_TIMER) && run_enable_bit) ||
         (pw_state_ff == ecp_pkg::ECP_PW_MEASURE));

    ecp_prescaler #(
        .SEL_W (ecp_pkg::ECP_PSC_SEL_W),
        .CNT_W (ecp_pkg::ECP_PSC_CNT_W)
    ) u_prescaler (
        .clk  (clk),
        .srst (srst),
        .run  (psc_run),
        .sel  (prescale_rate_sel),
        .tick (psc_tick)
    );

    // ------------------------------------------------------------------
    // Pulse width sequencer.
    // ------------------------------------------------------------------
    // Only a pin transition starts a measurement: a pin already at the active
    // level when armed does not start a measurement.
    assign pw_start_edge = active_edge_select ? pin_rise : pin_fall;
    assign pw_stop_edge  = active_edge_select ? pin_fall : pin_rise;

    always_comb begin
        nxt_pw_state = pw_state_ff;
        pw_done      = 1'b0;
        case (pw_state_ff)
            ecp_pkg::ECP_PW_IDLE: begin
                // Arming only; no counting yet.
                if ((mode == ecp_pkg::ECP_MODE_PULSE) && run_enable_bit) begin
                    nxt_pw_state = ecp_pkg::ECP_PW_ARMED;
                end
            end
            ecp_pkg::ECP_PW_ARMED: begin
                if ((mode != ecp_pkg::ECP_MODE_PULSE) || !run_enable_bit) begin
                    nxt_pw_state = ecp_pkg::ECP_PW_IDLE;
                end else if (pw_start_edge) begin
                    nxt_pw_state = ecp_pkg::ECP_PW_MEASURE;
                end
            end
            ecp_pkg::ECP_PW_MEASURE: begin
                if ((mode != ecp_pkg::ECP_MODE_PULSE) || !run_enable_bit) begin
                    nxt_pw_state = ecp_pkg::ECP_PW_IDLE;
                end else if (pw_stop_edge) begin
                    // Back to idle with the enable cleared, so further
                    // edges are ignored until software rearms.
                    nxt_pw_state = ecp_pkg::ECP_PW_IDLE;
                    pw_done      = 1'b1;
                end
            end
            default: begin
                nxt_pw_state = ecp_pkg::ECP_PW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pw_state_ff <= ecp_pkg::ECP_PW_IDLE;
        end else begin
            pw_state_ff <= nxt_pw_state;
        end
    end

    // ------------------------------------------------------------------
    // Control register. A software write in the same cycle as the
    // hardware clear wins, so a rearm is never lost.
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (pw_done && (mode == ecp_pkg::ECP_MODE_PULSE)) begin
            // Hardware clears the enable only here.
            nxt_ctrl[ecp_pkg::ECP_CTRL_RUN] = 1'b0;
        end
        if (wr_ctrl) begin
            nxt_ctrl = wb_dat_i[7:0] & ecp_pkg::ECP_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= ecp_pkg::ECP_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Count source selection.
    // ------------------------------------------------------------------
    always_comb begin
        cnt_tick = 1'b0;
        case (mode)
            ecp_pkg::ECP_MODE_EVENT: begin
                // Pin edges count directly, also in power-down.
                cnt_tick = run_enable_bit &&
                           (active_edge_select ? pin_fall : pin_rise);
            end
            ecp_pkg::ECP_MODE_TIMER: begin
                cnt_tick = run_enable_bit && psc_tick;
            end
            ecp_pkg::ECP_MODE_PULSE: begin
                cnt_tick = (pw_state_ff == ecp_pkg::ECP_PW_MEASURE) &&
                           run_enable_bit && psc_tick;
            end
            default: begin
                cnt_tick = 1'b0;
            end
        endcase
    end

    assign at_full  = (count_ff == {CNT_W{1'b1}});
    assign overflow = cnt_tick && at_full;
    assign wake_evt = overflow && power_down;

    // ------------------------------------------------------------------
    // Preload and counter.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            preload_ff <= '0;
        end else if (wr_preload) begin
            preload_ff <= wb_dat_i[CNT_W-1:0];
        end
    end

    // No tick reaches the counter when stopped, so the residual value of
    // a finished measurement stays readable.
    always_ff @(posedge clk) begin
        if (srst) begin
            count_ff <= '0;
        end else if (wr_preload && !run_enable_bit) begin
            count_ff <= wb_dat_i[CNT_W-1:0];
        end else if (overflow) begin
            count_ff <= preload_ff;
        end else if (cnt_tick) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and wake-up.
    // ------------------------------------------------------------------
    // Write one to clear; a new event in the same cycle stays set.
    always_ff @(posedge clk) begin
        if (srst) begin
            status_ff <= '0;
        end else begin
            status_ff[ecp_pkg::ECP_IRQ_OVF] <= overflow ||
                (status_ff[ecp_pkg::ECP_IRQ_OVF] &&
                 !(wr_status && wb_dat_i[ecp_pkg::ECP_IRQ_OVF]));
            status_ff[ecp_pkg::ECP_IRQ_WAKE] <= wake_evt ||
                (status_ff[ecp_pkg::ECP_IRQ_WAKE] &&
                 !(wr_status && wb_dat_i[ecp_pkg::ECP_IRQ_WAKE]));
        end
    end

    // Mask bit 0 is the timer interrupt enable.
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_ff <= '0;
        end else if (wr_mask) begin
            mask_ff <= wb_dat_i[ecp_pkg::ECP_IRQ_W-1:0];
        end
    end

    assign irq = |(status_ff & mask_ff);

    // The wake request ignores the mask, as a sleeping core must wake on
    // any overflow it was left counting toward.
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= wake_evt;
        end
    end

endmodule

// >>> ecp_pulse_src.sv
// Behavioural pulse source that drives the shared count input pin.
`timescale 1ns/1ps
module ecp_pulse_src (
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'h0;

    // Levels are held for whole clocks; the pin has no pull, so it always
    // shows a driven level and never a stale one.
    task automatic level(input logic v, input int n);
        @(posedge clk);
        pin <= v;
        repeat (n) @(posedge clk);
    endtask

    task automatic pulses(input int n, input int w);
        repeat (n) begin
            level(~pin, w);
            level(~pin, w);
        end
    endtask
endmodule

// >>> ecp_timer_asserts.sv
// Port-level assertions for the event counter and pulse width timer.
`timescale 1ns/1ps
module ecp_timer_asserts #(
    parameter int CNT_W = 8
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        shared_count_input_pin,
    input wire logic        power_down,
    input wire logic        pin_as_timer_input,
    input wire logic        wake_req,
    input wire logic        irq
);
    logic       tk;
    logic       wr0;
    logic [1:0] mode_ff;
    logic [1:0] mask_ff;
    assign tk  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr0 = tk & wb_we_i & wb_sel_i[0];
    // Only software changes these fields, so a shadow tracks them exactly.
    always_ff @(posedge clk) begin
        if (srst)
            mode_ff <= 2'h0;
        else if (wr0 && wb_adr_i == ecp_pkg::ECP_OFS_CTRL)
            mode_ff <= wb_dat_i[7:6];
    end
    always_ff @(posedge clk) begin
        if (srst)
            mask_ff <= 2'h0;
        else if (wr0 && wb_adr_i == ecp_pkg::ECP_OFS_MASK)
            mask_ff <= wb_dat_i[1:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_ACK_NEXT: assert property (tk |=> wb_ack_o)
        else $error("request not acknowledged");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_PIN_SEL: assert property (pin_as_timer_input == mode_ff[0])
        else $error("pin select does not follow mode");
    AST_IRQ_MASK: assert property (irq |-> mask_ff != 2'h0)
        else $error("irq while all sources masked");
    AST_WAKE_PD: assert property (wake_req |-> $past(power_down))
        else $error("wake outside power down");
    AST_WAKE_EVT: assert property (wake_req |-> $past(mode_ff) == 2'h1)
        else $error("wake outside event mode");
    AST_WAKE_ONE: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    AST_RD_CTRL: assert property (tk && !wb_we_i &&
        wb_adr_i == ecp_pkg::ECP_OFS_CTRL |=>
        wb_dat_o[31:5] == {24'h0, mode_ff, 1'h0})
        else $error("control readback wrong");
    COV_IRQ: cover property ($rose(irq));
    COV_WAKE: cover property (wake_req);
    COV_PULSE: cover property (mode_ff == 2'h3 && pin_as_timer_input);
endmodule

bind ecp_timer ecp_timer_asserts #(.CNT_W(CNT_W)) ecp_timer_asserts_inst (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .shared_count_input_pin(shared_count_input_pin),
    .power_down(power_down), .pin_as_timer_input(pin_as_timer_input),
    .wake_req(wake_req), .irq(irq)
);

// >>> test_ecp_timer.sv
// Self-checking bench for the event counter and pulse width timer.
`timescale 1ns/1ps
module test_ecp_timer;
    logic        clk;
    logic        srst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        pin;
    logic        pd;
    logic        pin_sel;
    logic        wake;
    logic        irq;
    logic [31:0] q;
    int          errors;
    int          comparisons;
    int          cnt_m;
    int          pre_m;
    int          st_m;
    int          wakes;
    int          t_ack;
    int          ncyc;

    ecp_timer ecp_timer_inst (
        .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .shared_count_input_pin(pin),
        .power_down(pd), .pin_as_timer_input(pin_sel),
        .wake_req(wake), .irq(irq)
    );
    ecp_pulse_src ecp_pulse_src_inst (.clk(clk), .pin(pin));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        ncyc <= ncyc + 1;
        if (wake === 1'h1)
            wakes <= wakes + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input int d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        if (ack !== 1'h1) begin
            errors++;
            tally_and_finish();
        end else begin
            q = rdat;
            t_ack = ncyc;
            cyc <= 1'h0;
            stb <= 1'h0;
        end
    endtask

    // Reference counter: counts up, reloads from preload past full scale.
    task automatic ev(input int n);
        repeat (n) begin
            if (cnt_m == 255) begin
                cnt_m = pre_m;
                st_m |= pd ? 3 : 1;
            end else
                cnt_m++;
        end
    endtask

    function automatic logic [31:0] near(logic [31:0] s, int e, int t);
        return (s >= e - t && s <= e + t) ? 32'h1 : 32'h0;
    endfunction

    initial begin
        int r;
        int w;
        srst = 1'h1;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 8'h0;
        sel = 4'hF;
        wdat = 32'h0;
        pd = 1'h0;
        r = $urandom(32'hF6A4);
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        bus(1'h1, 8'h14, 32'hFF);
        for (int i = 0; i < 6; i++) begin
            bus(1'h0, 8'(4 * i), 0);
            check(q, 32'h0);
        end
        bus(1'h1, 8'h00, 32'h3F);
        bus(1'h0, 8'h00, 0);
        check(q, 32'h1F);
        ecp_pulse_src_inst.pulses(3, 2);
        bus(1'h0, 8'h08, 0);
        check(q, 32'h0);
        bus(1'h1, 8'h00, 32'h40);
        check(32'(pin_sel), 32'h1);
        bus(1'h1, 8'h04, 32'hFC);
        pre_m = 252;
        cnt_m = 252;
        bus(1'h0, 8'h08, 0);
        check(q, cnt_m);
        bus(1'h1, 8'h10, 32'h1);
        bus(1'h1, 8'h00, 32'h57);
        w = 4 + $urandom % 3;
        ecp_pulse_src_inst.pulses(w, 2);
        ev(w);
        bus(1'h0, 8'h08, 0);
        check(q, cnt_m);
        bus(1'h0, 8'h0C, 0);
        check(q, st_m);
        check(32'(irq), 32'h1);
        check(wakes, 32'h0);
        bus(1'h1, 8'h04, 32'h10);
        pre_m = 16;
        bus(1'h0, 8'h08, 0);
        check(q, cnt_m);
        bus(1'h1, 8'h00, 32'h5F);
        ecp_pulse_src_inst.pulses(6, 2);
        ev(6);
        bus(1'h0, 8'h08, 0);
        check(q, cnt_m);
        bus(1'h0, 8'h00, 0);
        check(q, 32'h5F);
        bus(1'h1, 8'h10, 32'h0);
        check(32'(irq), 32'h0);
        bus(1'h1, 8'h0C, 32'h1);
        st_m = 0;
        bus(1'h0, 8'h0C, 0);
        check(q, st_m);
        bus(1'h1, 8'h00, 32'h48);
        bus(1'h1, 8'h04, 32'hFE);
        pre_m = 254;
        cnt_m = 254;
        @(posedge clk);
        pd <= 1'h1;
        w = wakes;
        bus(1'h1, 8'h00, 32'h5F);
        ecp_pulse_src_inst.pulses(3, 2);
        ev(3);
        bus(1'h0, 8'h0C, 0);
        check(q, st_m);
        check(wakes - w, 32'h1);
        bus(1'h0, 8'h08, 0);
        check(q, cnt_m);
        pd <= 1'h0;
        for (int p = 0; p < 8; p++) begin
            bus(1'h1, 8'h00, 32'h80 | p);
            bus(1'h1, 8'h04, 32'h0);
            bus(1'h1, 8'h00, 32'h90 | p);
            w = t_ack;
            repeat (40 << p) @(posedge clk);
            bus(1'h1, 8'h00, 32'h80 | p);
            w = (t_ack - w) >> p;
            bus(1'h0, 8'h08, 0);
            check(near(q, w, 1), 32'h1);
            r = q;
            repeat (9) @(posedge clk);
            bus(1'h0, 8'h08, 0);
            check(q, r);
        end
        check(32'(pin_sel), 32'h0);
        bus(1'h1, 8'h00, 32'hC0);
        check(32'(pin_sel), 32'h1);
        bus(1'h1, 8'h04, 32'h0);
        ecp_pulse_src_inst.level(1'h1, 4);
        bus(1'h1, 8'h00, 32'hD0);
        repeat (20) @(posedge clk);
        bus(1'h0, 8'h08, 0);
        check(q, 32'h0);
        w = 10 + $urandom % 20;
        ecp_pulse_src_inst.level(1'h0, w);
        ecp_pulse_src_inst.level(1'h1, 4);
        bus(1'h0, 8'h00, 0);
        check(q, 32'hC0);
        bus(1'h0, 8'h08, 0);
        check(near(q, w + 1, 2), 32'h1);
        r = q;
        ecp_pulse_src_inst.pulses(2, 3);
        bus(1'h0, 8'h08, 0);
        check(q, r);
        bus(1'h1, 8'h00, 32'hC8);
        bus(1'h1, 8'h04, 32'h0);
        bus(1'h1, 8'h00, 32'hD8);
        ecp_pulse_src_inst.level(1'h0, 4);
        bus(1'h0, 8'h08, 0);
        check(q, 32'h0);
        ecp_pulse_src_inst.level(1'h1, w);
        ecp_pulse_src_inst.level(1'h0, 4);
        bus(1'h0, 8'h00, 0);
        check(q, 32'hC8);
        bus(1'h0, 8'h08, 0);
        check(near(q, w + 1, 2), 32'h1);
        tally_and_finish();
    end
endmodule
